// ---- rtl/adc_ctrl_pkg.sv ----
// Constants, register map and carrier types for the converter control block.
// Assumes a classic Wishbone slave with 32-bit data and a single system clock.
//
// What this block does
// - Done flag sets on every finish, no compare.
// - With compare on, set only if true.
// - Control write or low result read clears done.
// - Done plus enable and mask raise the interrupt.
// - Single mode: one conversion per trigger.
// - Continuous mode: back-to-back after trigger.
// - Low five control bits choose channel.
// - Channel code passes to the core as written, undecoded.
// - All-ones channel powers off, no extra conversion.
// - Single mode idles low-power after finishing.
// - Four clock sources, bus clock after reset.
// - Selected clock divided by 1, 2, 4, 8.
// - Local clock keeps running in wait, stop3.
// - Alternate clock usable in wait, not stop.
// - Reference clock feeds the alternate input.
// - Trigger from counter overflow or request pin.
// - Rising trigger edge starts; busy edges ignored.
// - Resolution 12, 10 or 8 bits.
package adc_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFS_CONFIG             = 8'h04;
	localparam logic [7:0] OFS_RESULT_HIGH        = 8'h08;
	localparam logic [7:0] OFS_RESULT_LOW         = 8'h0C;
	localparam logic [7:0] OFS_COMPARE            = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS         = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK           = 8'h18;

	// Field positions.
	localparam int BIT_DONE   = 7;
	localparam int BIT_IEN    = 6;
	localparam int BIT_CONT   = 5;
	localparam int CFG_CLK_LO = 0;
	localparam int CFG_DIV_LO = 2;
	localparam int CFG_MOD_LO = 4;
	localparam int CFG_HWT    = 6;
	localparam int CFG_TSEL   = 7;
	localparam int CFG_CFE    = 8;
	localparam int CFG_CGT    = 9;

	// Reset values and special codes.
	localparam logic [4:0] CHAN_OFF      = 5'h1F;
	localparam logic [4:0] CHAN_RESERVED = 5'h1C;
	localparam logic [4:0] CHAN_REF_HIGH = 5'h1D;
	localparam logic [4:0] CHAN_REF_LOW  = 5'h1E;
	localparam logic [4:0] CHAN_TEMP     = 5'h1A;
	localparam logic [4:0] CHAN_BANDGAP  = 5'h1B;
	localparam logic [7:0] SC1_RESET     = 8'h1F;
	localparam logic [9:0] CFG_RESET     = 10'h000;

	// Conversion clock cycles spent sampling before the first trial bit.
	localparam logic [4:0] SAMPLE_CYCLES = 5'h04;

	typedef enum logic [1:0] {
		CLK_BUS      = 2'h0,
		CLK_BUS_HALF = 2'h1,
		CLK_ALT      = 2'h2,
		CLK_LOCAL    = 2'h3
	} clk_src_t;

	typedef enum logic [1:0] {
		RES_8  = 2'h0,
		RES_12 = 2'h1,
		RES_10 = 2'h2
	} res_mode_t;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_IDLE = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

	// Power-mode inputs from the system.
	typedef struct packed {
		logic wait_mode;
		logic stop2;
		logic stop3;
	} power_mode_t;

	// Request to the analog core.
	typedef struct packed {
		logic       enable;
		logic [4:0] channel;
		logic [1:0] resolution;
		logic       sample;
		logic [3:0] bit_index;
	} core_ctrl_t;

endpackage : adc_ctrl_pkg

// ---- rtl/adc_conversion_control.sv ----
// Control sequencer for a successive-approximation converter.
// Assumes a classic Wishbone master on SYS_CLK; clocks and trigger pins are asynchronous.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps

module adc_conversion_control (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RST_N,
	input  wire logic [7:0]               WB_ADR_I,
	input  wire logic [31:0]              WB_DAT_I,
	output logic      [31:0]              WB_DAT_O,
	input  wire logic                     WB_WE_I,
	input  wire logic [3:0]               WB_SEL_I,
	input  wire logic                     WB_CYC_I,
	input  wire logic                     WB_STB_I,
	output logic                          WB_ACK_O,
	output logic                          IRQ,
	input  wire logic                     EXT_REFERENCE_CLOCK,
	input  wire logic                     LOCAL_ASYNC_CLOCK,
	input  wire logic                     RTC_OVERFLOW,
	input  wire logic                     IRQ_PIN,
	input  wire adc_ctrl_pkg::power_mode_t POWER_MODE,
	input  wire logic                     COMPARATOR_HIGH,
	output adc_ctrl_pkg::core_ctrl_t      CORE_CTRL,
	output logic                          CONVERSION_CLOCK_EN,
	output logic                          BUSY
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0]  sc1;
		logic [9:0]  cfg;
		logic [11:0] result;
		logic [11:0] compare;
		logic [11:0] sar;
		logic        irq_status;
		logic        irq_mask;
		conv_state_t state;
		logic [3:0]  bit_index;
		logic [4:0]  sample_cnt;
		logic        sampling;
		logic [2:0]  div_cnt;
		logic        half_tgl;
		logic [1:0]  alt_sync;
		logic        alt_prev;
		logic [1:0]  loc_sync;
		logic        loc_prev;
		logic [1:0]  rtc_sync;
		logic [1:0]  pin_sync;
		logic        trig_prev;
		logic [1:0]  cmp_sync;
		logic        ack;
		logic [31:0] rdata;
		logic        irq;
		logic        ck_en;
		logic        busy;
		core_ctrl_t  core;
	} state_t;

	state_t cur;
	state_t nxt;

	// ----------------------------------------------------------------
	// Combinational next-state logic
	// ----------------------------------------------------------------

	logic        acc;
	logic        wr_sc1;
	logic        rd_low;
	logic        src_tick;
	logic        div_tick;
	logic        trig;
	logic        trig_rise;
	logic        conv_done;
	logic        cmp_true;
	logic        set_done;
	logic [2:0]  div_max;
	logic [3:0]  top_bit;
	logic [11:0] trial;
	logic [11:0] mask_val;

	// Whole next state in one process; one clock, slow rates are enable pulses.
	always_comb begin
		nxt = cur;
		acc = WB_CYC_I & WB_STB_I & ~cur.ack;
		wr_sc1 = acc & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == OFS_STATUS_CONTROL_ONE);
		rd_low = acc & ~WB_WE_I & (WB_ADR_I == OFS_RESULT_LOW);
		nxt.ack = acc;
		nxt.rdata = 32'h0000_0000;
		src_tick = 1'b0;
		div_tick = 1'b0;
		trig = 1'b0;
		conv_done = 1'b0;
		cmp_true = 1'b0;
		set_done = 1'b0;
		trial = 12'h000;

		// Resynchronise the clock, trigger and comparator inputs before use.
		nxt.alt_sync = {cur.alt_sync[0], EXT_REFERENCE_CLOCK};
		nxt.alt_prev = cur.alt_sync[1];
		nxt.loc_sync = {cur.loc_sync[0], LOCAL_ASYNC_CLOCK};
		nxt.loc_prev = cur.loc_sync[1];
		nxt.rtc_sync = {cur.rtc_sync[0], RTC_OVERFLOW};
		nxt.pin_sync = {cur.pin_sync[0], IRQ_PIN};
		nxt.cmp_sync = {cur.cmp_sync[0], COMPARATOR_HIGH};
		nxt.half_tgl = ~cur.half_tgl;

		// Source clock selection as rising-edge enables of the bus clock.
		unique case (clk_src_t'(cur.cfg[CFG_CLK_LO +: 2]))
			CLK_BUS:      src_tick = 1'b1;
			CLK_BUS_HALF: src_tick = cur.half_tgl;
			// The alternate clock stops in stop modes; the local one keeps running.
			CLK_ALT:      src_tick = cur.alt_sync[1] & ~cur.alt_prev
				& ~POWER_MODE.stop2 & ~POWER_MODE.stop3;
			CLK_LOCAL:    src_tick = cur.loc_sync[1] & ~cur.loc_prev;
			default:      src_tick = 1'b0;
		endcase

		// Divide by 1, 2, 4 or 8.
		div_max = 3'((4'h1 << cur.cfg[CFG_DIV_LO +: 2]) - 4'h1);
		if (src_tick) begin
			if (cur.div_cnt >= div_max) begin
				nxt.div_cnt = 3'h0;
				div_tick = 1'b1;
			end else begin
				nxt.div_cnt = cur.div_cnt + 3'h1;
			end
		end
		nxt.ck_en = div_tick & (cur.state == ST_CONV);

		// Trigger source and rising edge detection.
		trig = cur.cfg[CFG_TSEL] ? cur.pin_sync[1] : cur.rtc_sync[1];
		nxt.trig_prev = trig;
		trig_rise = trig & ~cur.trig_prev & cur.cfg[CFG_HWT];

		unique case (res_mode_t'(cur.cfg[CFG_MOD_LO +: 2]))
			RES_12:  top_bit = 4'hB;
			RES_10:  top_bit = 4'h9;
			default: top_bit = 4'h7;
		endcase
		mask_val = 12'hFFF >> (4'hB - top_bit);

		// Successive approximation steps on conversion clock enables.
		unique case (cur.state)
			ST_OFF: begin
				nxt.state = ST_OFF;
			end
			ST_IDLE: begin
				// Ignore edges while busy; only idle edges launch.
				if (trig_rise) begin
					nxt.state = ST_CONV;
					nxt.sar = 12'h000;
					nxt.bit_index = top_bit;
					nxt.sampling = 1'b1;
					nxt.sample_cnt = SAMPLE_CYCLES;
				end
			end
			ST_CONV: begin
				if (div_tick) begin
					if (cur.sampling) begin
						nxt.sample_cnt = cur.sample_cnt - 5'h01;
						if (cur.sample_cnt == 5'h01) begin
							nxt.sampling = 1'b0;
						end
					end else begin
						trial = cur.sar | (12'h001 << cur.bit_index);
						nxt.sar = cur.cmp_sync[1] ? trial : cur.sar;
						if (cur.bit_index == 4'h0) begin
							conv_done = 1'b1;
						end else begin
							nxt.bit_index = cur.bit_index - 4'h1;
						end
					end
				end
			end
			default: nxt.state = ST_IDLE;
		endcase

		if (conv_done) begin
			nxt.result = nxt.sar & mask_val;
			cmp_true = cur.cfg[CFG_CGT] ? ((nxt.sar & mask_val) >= cur.compare)
				: ((nxt.sar & mask_val) < cur.compare);
			set_done = ~cur.cfg[CFG_CFE] | cmp_true;
			if (cur.sc1[BIT_CONT]) begin
				nxt.sar = 12'h000;
				nxt.bit_index = top_bit;
				nxt.sampling = 1'b1;
				nxt.sample_cnt = SAMPLE_CYCLES;
			end else begin
				nxt.state = ST_IDLE;
			end
		end

		// Control write: clears done; restarts, waits idle for a hardware trigger or powers down.
		if (wr_sc1) begin
			nxt.sc1 = {1'b0, WB_DAT_I[6:0]};
			if (WB_DAT_I[4:0] == CHAN_OFF) begin
				nxt.state = ST_OFF;
			end else if (cur.cfg[CFG_HWT]) begin
				nxt.state = ST_IDLE;
			end else begin
				nxt.state = ST_CONV;
				nxt.sar = 12'h000;
				nxt.bit_index = top_bit;
				nxt.sampling = 1'b1;
				nxt.sample_cnt = SAMPLE_CYCLES;
			end
		end else if (rd_low) begin
			nxt.sc1[BIT_DONE] = 1'b0;
		end
		// A finishing conversion wins over a simultaneous clear.
		if (set_done) begin
			nxt.sc1[BIT_DONE] = 1'b1;
			nxt.irq_status = 1'b1;
		end

		// Other register writes.
		if (acc & WB_WE_I & WB_SEL_I[0]) begin
			unique case (WB_ADR_I)
				OFS_CONFIG:     nxt.cfg[7:0] = WB_DAT_I[7:0];
				OFS_COMPARE:    nxt.compare[7:0] = WB_DAT_I[7:0];
				OFS_IRQ_MASK:   nxt.irq_mask = WB_DAT_I[BIT_DONE];
				OFS_IRQ_STATUS: if (WB_DAT_I[BIT_DONE] & ~set_done) nxt.irq_status = 1'b0;
				default:        ;
			endcase
		end
		if (acc & WB_WE_I & WB_SEL_I[1]) begin
			if (WB_ADR_I == OFS_CONFIG) nxt.cfg[9:8] = WB_DAT_I[9:8];
			if (WB_ADR_I == OFS_COMPARE) nxt.compare[11:8] = WB_DAT_I[11:8];
		end

		// Read mux; unmapped addresses read as zero.
		if (acc & ~WB_WE_I) begin
			unique case (WB_ADR_I)
				OFS_STATUS_CONTROL_ONE: nxt.rdata = {24'h000000, cur.sc1};
				OFS_CONFIG:             nxt.rdata = {22'h000000, cur.cfg};
				OFS_RESULT_HIGH:        nxt.rdata = {28'h0000000, cur.result[11:8]};
				OFS_RESULT_LOW:         nxt.rdata = {24'h000000, cur.result[7:0]};
				OFS_COMPARE:            nxt.rdata = {20'h00000, cur.compare};
				OFS_IRQ_STATUS:         nxt.rdata = {24'h000000, cur.irq_status, 7'h00};
				OFS_IRQ_MASK:           nxt.rdata = {24'h000000, cur.irq_mask, 7'h00};
				default:                nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Interrupt needs both the done enable and the mask.
		nxt.irq = nxt.irq_status & nxt.irq_mask & nxt.sc1[BIT_IEN];

		// Busy is registered so that the port comes straight from a flip-flop.
		nxt.busy = (nxt.state == ST_CONV);
		nxt.core.enable = (nxt.state == ST_CONV);
		nxt.core.channel = nxt.sc1[4:0];
		nxt.core.resolution = nxt.cfg[CFG_MOD_LO +: 2];
		nxt.core.sample = nxt.sampling & (nxt.state == ST_CONV);
		nxt.core.bit_index = nxt.bit_index;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Synchronous reset; everything starts powered off on the bus clock.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cur <= '0;
			cur.sc1 <= SC1_RESET;
			cur.cfg <= CFG_RESET;
			cur.state <= ST_OFF;
			cur.core.channel <= CHAN_OFF;
		end else begin
			cur <= nxt;
		end
	end

	assign WB_ACK_O = cur.ack;
	assign WB_DAT_O = cur.rdata;
	assign IRQ = cur.irq;
	assign CORE_CTRL = cur.core;
	assign CONVERSION_CLOCK_EN = cur.ck_en;
	assign BUSY = cur.busy;

endmodule // adc_conversion_control

// ---- tb/analog_core_model.sv ----
// Holds a behavioural analog core that answers the successive-approximation trials.
// Assumes the core request struct of the package and the block's system clock.
`timescale 1ns/10ps

module analog_core_model
	import adc_ctrl_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire core_ctrl_t CORE_CTRL,
	output logic            COMPARATOR_HIGH
);
	// ----------------------------------------------------------------
	// Comparator
	// ----------------------------------------------------------------
	logic [11:0] level = 12'hA5C;
	// Outside a trial the output toggles, so nothing may rely on a stale level.
	always_ff @(posedge SYS_CLK) begin
		if (CORE_CTRL.enable && !CORE_CTRL.sample)
			COMPARATOR_HIGH <= level[CORE_CTRL.bit_index];
		else
			COMPARATOR_HIGH <= !COMPARATOR_HIGH;
	end
endmodule // analog_core_model

// ---- tb/adc_conversion_control_checker.sv ----
// Holds the concurrent checks on the converter control block's ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps

module adc_conversion_control_checker
	import adc_ctrl_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_WE_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_ACK_O,
	input wire logic        IRQ,
	input wire core_ctrl_t  CORE_CTRL,
	input wire logic        CONVERSION_CLOCK_EN,
	input wire logic        BUSY
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------------------------------
	// Sequences and assertions
	// ----------------------------------------------------------------
	sequence sc1_wr;
		WB_ACK_O && WB_WE_I && WB_ADR_I == OFS_STATUS_CONTROL_ONE;
	endsequence
	sequence request;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	AST_ACK_TAKE: assert property (request |=> WB_ACK_O) else $error("ack missing");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	AST_IRQ_IEN_OFF: assert property (sc1_wr ##0 !WB_DAT_I[6] |-> ##[1:2] !IRQ)
		else $error("irq without enable");
	AST_OFF_IDLE: assert property (sc1_wr ##0 WB_DAT_I[4:0] == CHAN_OFF |-> ##[1:3] !BUSY)
		else $error("busy after off");
	AST_CLKEN_BUSY: assert property (CONVERSION_CLOCK_EN |-> BUSY || $past(BUSY))
		else $error("clock out of conversion");
	AST_REFUSED_ZERO: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h1C |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	// The channel changes at the taking edge, so it is first seen new together with ack.
	AST_CH_STABLE: assert property (BUSY && $past(BUSY) && !WB_ACK_O
		|-> $stable(CORE_CTRL.channel)) else $error("channel moved");
	AST_RESET_IDLE: assert property ($rose(RST_N) |-> !BUSY && !IRQ) else $error("not idle");
endmodule // adc_conversion_control_checker

bind adc_conversion_control adc_conversion_control_checker chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ), .CORE_CTRL(CORE_CTRL),
	.CONVERSION_CLOCK_EN(CONVERSION_CLOCK_EN), .BUSY(BUSY));

// ---- tb/test_adc_conversion_control.sv ----
// Holds the self-checking bench of the converter control block.
// Assumes the analog core model on the far side and a classic Wishbone master here.
`timescale 1ns/10ps

module test_adc_conversion_control;
	import adc_ctrl_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        rtc = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] dat_o;
	logic        ack, irq, comp, clk_en, busy;
	core_ctrl_t  core;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          ticks = 0;
	// ----------------------------------------------------------------
	// Clock, model, design
	// ----------------------------------------------------------------
	initial begin
		forever #2.5 clk = !clk;
	end
	analog_core_model model (.SYS_CLK(clk), .CORE_CTRL(core), .COMPARATOR_HIGH(comp));
	// Async clocks and the pin trigger are tied; their paths stay for a later bench.
	adc_conversion_control uut (.SYS_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_ACK_O(ack), .IRQ(irq), .EXT_REFERENCE_CLOCK(1'b0), .LOCAL_ASYNC_CLOCK(1'b0),
		.RTC_OVERFLOW(rtc), .IRQ_PIN(1'b0), .POWER_MODE(3'h0), .COMPARATOR_HIGH(comp),
		.CORE_CTRL(core), .CONVERSION_CLOCK_EN(clk_en), .BUSY(busy));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task stop_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Values are read before the edge's updates land, so ack is seen as sampled.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20)
			cmp8(8'h00, 8'h01);
	endtask
	task wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 400 && busy !== lvl; i++)
			@(posedge clk);
		cmp8({7'h0, busy}, {7'h0, lvl});
	endtask
	task conv_done;
		wait_busy(1'b1);
		wait_busy(1'b0);
		wb(1'b0, OFS_STATUS_CONTROL_ONE, 32'h0);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		wb(1'b0, OFS_STATUS_CONTROL_ONE, 32'h0);
		cmp8(q[7:0], 8'h1F);
		wb(1'b0, OFS_CONFIG, 32'h0);
		cmp8(q[7:0], 8'h00);
		wb(1'b1, 8'h1C, 32'hFF);
		wb(1'b0, 8'h1C, 32'h0);
		cmp8(q[7:0], 8'h00);
	endtask
	task t_single;
		wb(1'b1, OFS_IRQ_MASK, 32'h80);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h43);
		conv_done();
		cmp8(q[7:0], 8'hC3);
		cmp8({7'h0, irq}, 8'h01);
		cmp8({7'h0, core.enable}, 8'h00);
		wb(1'b0, OFS_RESULT_LOW, 32'h0);
		wb(1'b0, OFS_STATUS_CONTROL_ONE, 32'h0);
		cmp8(q[7:0], 8'h43);
		wb(1'b1, OFS_IRQ_STATUS, 32'h80);
		repeat (2) @(posedge clk);
		cmp8({7'h0, irq}, 8'h00);
	endtask
	task t_compare;
		wb(1'b1, OFS_COMPARE, 32'h0);
		wb(1'b1, OFS_CONFIG, 32'h100);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h03);
		conv_done();
		cmp8(q[7:0], 8'h03);
		wb(1'b1, OFS_CONFIG, 32'h300);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h03);
		conv_done();
		cmp8(q[7:0], 8'h83);
		wb(1'b1, OFS_CONFIG, 32'h0);
	endtask
	// Divide by 8 leaves the synchronised comparator time to settle before each bit.
	task t_result;
		wb(1'b1, OFS_CONFIG, 32'h1C);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h1D);
		wait_busy(1'b1);
		cmp8({3'h0, core.channel}, {3'h0, CHAN_REF_HIGH});
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h1E);
		cmp8({7'h0, busy}, 8'h01);
		cmp8({3'h0, core.channel}, {3'h0, CHAN_REF_LOW});
		conv_done();
		wb(1'b0, OFS_RESULT_HIGH, 32'h0);
		cmp8(q[7:0], 8'h0A);
		wb(1'b0, OFS_RESULT_LOW, 32'h0);
		cmp8(q[7:0], 8'h5C);
		wb(1'b1, OFS_CONFIG, 32'h0);
	endtask
	task t_cont;
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h25);
		repeat (150) @(posedge clk);
		wb(1'b0, OFS_RESULT_LOW, 32'h0);
		repeat (150) @(posedge clk);
		wb(1'b0, OFS_STATUS_CONTROL_ONE, 32'h0);
		cmp8(q[7:0], 8'hA5);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h1F);
		repeat (150) @(posedge clk);
		cmp8({7'h0, busy}, 8'h00);
	endtask
	task t_hwt;
		wb(1'b1, OFS_CONFIG, 32'h40);
		wb(1'b1, OFS_STATUS_CONTROL_ONE, 32'h05);
		repeat (20) @(posedge clk);
		cmp8({7'h0, busy}, 8'h00);
		rtc <= 1'b1;
		conv_done();
		rtc <= 1'b0;
		cmp8(q[7:0], 8'h85);
	endtask
	// ----------------------------------------------------------------
	// Sequence and timeout
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_single();
		t_compare();
		t_result();
		t_cont();
		t_hwt();
		stop_test();
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks > 20000) begin
			n_fail++;
			stop_test();
		end
	end
endmodule // test_adc_conversion_control
